// ==== rtl/adc_ctrl_params.svh ====
// Offsets, field positions, reset values and timing figures for the ADC control
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH
// ==========================================================
// Register addresses on the special function register bus
`define SFR_MODE 8'hD1
`define SFR_CTRL1 8'hD2
`define SFR_AUXCON 8'hD3
`define SFR_DECIM 8'hD4
`define SFR_STATUS 8'hD8
`define SFR_RES0L 8'hD9
`define SFR_RES0M 8'hDA
`define SFR_RES0H 8'hDB
`define SFR_RES1M 8'hDC
`define SFR_RES1H 8'hDD
`define SFR_RES1L 8'hDE
`define SFR_OFS0L 8'hE1
`define SFR_OFS0M 8'hE2
`define SFR_OFS0H 8'hE3
`define SFR_GAIN0L 8'hE9
`define SFR_GAIN0M 8'hEA
`define SFR_GAIN0H 8'hEB
// ==========================================================
// Reset values
`define DECIM_RST 8'h45
`define MODE_RST 8'h08
`define CTRL1_RST 8'h07
`define AUXCON_RST 8'h00
// ==========================================================
// Status bit positions
`define ST_PRIMARY_READY_FLAG 7
`define ST_AUX_READY_FLAG 6
`define ST_CAL 5
`define ST_NOREF 4
`define ST_PRIMARY_ERROR_FLAG 3
`define ST_AUX_ERROR_FLAG 2
// ==========================================================
// Mode and control field positions
`define MODE_EN0 5
`define MODE_EN1 4
`define MODE_CHOP_OFF 3
`define CTRL1_BUFA 7
`define CTRL1_BUFB 6
`define AUX_TEMP_CHAN 4'hF
// ==========================================================
// Filter rate figures
`define DECIM_MIN_CHOP 8'h0D
`define CHOP_MULT 24
`define NOCHOP_MULT 8
`define CLK_HZ 50000000
`define BASE_HZ 32768
`define BASE_DIV (`CLK_HZ / `BASE_HZ)
`endif

// ==== rtl/adc_ctrl_pkg.sv ====
// Types shared by the ADC control and status logic
package adc_ctrl_pkg;
    // ==========================================================
    // Byte request on the special function register bus
    typedef struct packed {
        logic [7:0] addr;  // Register address
        logic wr;          // Write strobe, one cycle
        logic rd;          // Read strobe, one cycle
        logic [7:0] wdata; // Write data
    } sfr_req_t;
    // Single-bit request on the bit-addressable space
    typedef struct packed {
        logic [7:0] addr; // Bit address
        logic wr;         // Bit write strobe
        logic rd;         // Bit read strobe
        logic wdata;      // Bit value
    } bit_req_t;
    // Converter operating modes in the mode register
    typedef enum logic [2:0] {
        MODE_OFF = 3'b000,
        MODE_IDLE = 3'b001,
        MODE_SINGLE = 3'b010,
        MODE_CONT = 3'b011,
        MODE_ZCAL = 3'b100,
        MODE_FCAL = 3'b101,
        MODE_SZCAL = 3'b110,
        MODE_SFCAL = 3'b111
    } conv_mode_t;
endpackage : adc_ctrl_pkg

// ==== rtl/rate_divider.sv ====
// Conversion pacing counter counting base ticks to one filter period
`timescale 1ns/10ps
`default_nettype none
module rate_divider #(
    parameter int W = 13
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic base_tick,
    input wire logic run,
    input wire logic restart,
    input wire logic [W-1:0] period,
    output logic done
);
    logic [W-1:0] cnt_ff; // Base ticks seen in this period
    logic done_ff;        // Period complete pulse

    // ==========================================================
    // Period counter; restart drops any partial period
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= '0;
            done_ff <= 1'b0;
        end else if (restart || !run) begin
            cnt_ff <= '0;
            done_ff <= 1'b0;
        end else if (base_tick && (cnt_ff >= period - 1'b1)) begin
            cnt_ff <= '0;
            done_ff <= 1'b1;
        end else begin
            cnt_ff <= base_tick ? cnt_ff + 1'b1 : cnt_ff;
            done_ff <= 1'b0;
        end
    end

    assign done = done_ff;
endmodule : rate_divider
`default_nettype wire

// ==== rtl/adc_status_ctrl.sv ====
// Sigma-delta converter status, mode and decimation control registers
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_params.svh"
module adc_status_ctrl #(
    parameter int RES_W = 24,
    parameter logic [23:0] FACTORY_OFFSET = 24'h800000,
    parameter logic [23:0] FACTORY_GAIN = 24'h555555
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire adc_ctrl_pkg::sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    input wire adc_ctrl_pkg::bit_req_t bit_req,
    output logic bit_rdata,
    input wire logic [RES_W-1:0] primary_sample,
    input wire logic [RES_W-1:0] aux_sample,
    input wire logic ref_missing,
    output logic [RES_W-1:0] primary_result,
    output logic [RES_W-1:0] aux_result,
    output logic chop_enable,
    output logic buffer_disable,
    output logic [2:0] range_code
);
    import adc_ctrl_pkg::*;

    localparam int PW = 13; // Width of a period in base ticks

    // ==========================================================
    // Register state
    logic [7:0] mode_ff;   // Mode register
    logic [7:0] ctrl1_ff;  // Primary control one register
    logic [7:0] auxcon_ff; // Auxiliary control register
    logic [7:0] decim_ff;  // Decimation factor register
    logic primary_ready_flag_ff;         // Primary ready flag
    logic aux_ready_flag_ff;         // Auxiliary ready flag
    logic cal_ff;          // Calibration done flag
    logic noref_ff;        // Missing reference flag
    logic primary_error_flag_ff;         // Primary error flag
    logic aux_error_flag_ff;         // Auxiliary error flag
    logic [RES_W-1:0] res0_ff;  // Primary result
    logic [RES_W-1:0] res1_ff;  // Auxiliary result
    logic [RES_W-1:0] ofs0_ff;  // Primary offset coefficient
    logic [RES_W-1:0] gain0_ff; // Primary gain coefficient
    logic [7:0] rdata_ff;  // Byte read answer
    logic brdata_ff;       // Bit read answer
    logic chop_ff;         // Chop enable output
    logic bufdis_ff;       // Buffer disable output
    logic [2:0] range_ff;  // Range code output

    // ==========================================================
    // Synchronisers for the analog front-end inputs
    logic [RES_W-1:0] s0_meta_ff; // First stage, primary sample
    logic [RES_W-1:0] s0_ff;      // Second stage, primary sample
    logic [RES_W-1:0] s1_meta_ff; // First stage, auxiliary sample
    logic [RES_W-1:0] s1_ff;      // Second stage, auxiliary sample
    logic ref_meta_ff;            // First stage, reference detect
    logic ref_ff;                 // Second stage, reference detect

    // Two flops before any logic reads an outside level
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s0_meta_ff <= '0;
            s0_ff <= '0;
            s1_meta_ff <= '0;
            s1_ff <= '0;
            ref_meta_ff <= 1'b0;
            ref_ff <= 1'b0;
        end else begin
            s0_meta_ff <= primary_sample;
            s0_ff <= s0_meta_ff;
            s1_meta_ff <= aux_sample;
            s1_ff <= s1_meta_ff;
            ref_meta_ff <= ref_missing;
            ref_ff <= ref_meta_ff;
        end
    end

    // ==========================================================
    // Decoded mode and write strobes
    conv_mode_t mode_sel; // Operating mode field
    logic active;         // A conversion or calibration is running
    logic cal_mode;       // Running mode is a calibration
    logic mode_wr;        // Software writes the mode register
    logic aux_temp;       // Auxiliary input is the temperature sensor

    assign mode_sel = conv_mode_t'(mode_ff[2:0]);
    assign cal_mode = mode_ff[2];
    assign active = (mode_sel != MODE_OFF) && (mode_sel != MODE_IDLE);
    assign mode_wr = sfr_req.wr && (sfr_req.addr == `SFR_MODE);
    assign aux_temp = (auxcon_ff[3:0] == `AUX_TEMP_CHAN);

    // Per-bit software writes to the status register
    logic [7:0] sw_we;  // Status bit written this cycle
    logic [7:0] sw_val; // Value written to that bit

    // Byte writes hit every bit; bit writes hit one bit
    always_comb begin
        sw_we = 8'h00;
        sw_val = 8'h00;
        if (sfr_req.wr && (sfr_req.addr == `SFR_STATUS)) begin
            sw_we = 8'hFF;
            sw_val = sfr_req.wdata;
        end else if (bit_req.wr &&
                     (bit_req.addr[7:3] == `SFR_STATUS >> 3)) begin
            sw_we[bit_req.addr[2:0]] = 1'b1;
            sw_val[bit_req.addr[2:0]] = bit_req.wdata;
        end
    end

    // ==========================================================
    // Filter period from decimation factor and chop setting
    logic [7:0] decim_eff; // Factor the filter really uses
    logic [PW-1:0] period; // Output period in base ticks

    // With chop on, a factor below DECIM_MIN_CHOP is raised to it, in every mode
    always_comb begin
        decim_eff = decim_ff;
        if (!mode_ff[`MODE_CHOP_OFF] && decim_ff < `DECIM_MIN_CHOP) begin
            decim_eff = `DECIM_MIN_CHOP;
        end
        if (!mode_ff[`MODE_CHOP_OFF]) begin
            period = PW'(decim_eff) * PW'(`CHOP_MULT);
        end else begin
            period = PW'(decim_eff) * PW'(`NOCHOP_MULT);
        end
    end

    // ==========================================================
    // Base tick at the filter reference rate
    logic [10:0] base_cnt_ff; // Core clocks within one base tick
    logic base_tick_ff;       // One-cycle base tick

    // Divide the core clock down to the filter base rate
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            base_cnt_ff <= '0;
            base_tick_ff <= 1'b0;
        end else if (base_cnt_ff == 11'(`BASE_DIV - 1)) begin
            base_cnt_ff <= '0;
            base_tick_ff <= 1'b1;
        end else begin
            base_cnt_ff <= base_cnt_ff + 11'h001;
            base_tick_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Conversion pacing for each converter
    logic done0; // Primary conversion complete
    logic done1; // Auxiliary conversion complete

    rate_divider #(.W(PW)) u_rate0 (
        .clk(clk),
        .arst_n(arst_n),
        .base_tick(base_tick_ff),
        .run(active && mode_ff[`MODE_EN0]),
        .restart(mode_wr),
        .period(period),
        .done(done0)
    );

    rate_divider #(.W(PW)) u_rate1 (
        .clk(clk),
        .arst_n(arst_n),
        .base_tick(base_tick_ff),
        .run(active && mode_ff[`MODE_EN1]),
        .restart(mode_wr),
        .period(period),
        .done(done1)
    );

    // ==========================================================
    // Completion acceptance and clamping
    logic [RES_W-1:0] val0; // Primary value after reference clamp
    logic [RES_W-1:0] val1; // Auxiliary value after reference clamp
    logic clamp0;           // Primary value at either rail
    logic clamp1;           // Auxiliary value at either rail
    logic done1_q;          // Auxiliary completion that may finish
    logic acc0;             // Primary completion accepted
    logic acc1;             // Auxiliary completion accepted
    logic finish;           // Single shot or calibration ends

    assign val0 = ref_ff ? '1 : s0_ff;
    assign val1 = ref_ff ? '1 : s1_ff;
    assign clamp0 = (val0 == '1) || (val0 == '0);
    assign clamp1 = (val1 == '1) || (val1 == '0);
    // Temperature-sensor calibration on the auxiliary side hangs
    assign done1_q = done1 && !(cal_mode && aux_temp);
    // A clear in the same cycle lets the new completion through
    assign acc0 = done0 && !(primary_ready_flag_ff && !(sw_we[`ST_PRIMARY_READY_FLAG] &&
                  !sw_val[`ST_PRIMARY_READY_FLAG]) && !mode_wr);
    assign acc1 = done1_q && !(aux_ready_flag_ff && !(sw_we[`ST_AUX_READY_FLAG] &&
                  !sw_val[`ST_AUX_READY_FLAG]) && !mode_wr);
    assign finish = (mode_ff[`MODE_EN0] ? done0 : done1_q) &&
                    (mode_sel != MODE_CONT);

    // ==========================================================
    // Configuration registers written by software
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_ff <= `MODE_RST;
            ctrl1_ff <= `CTRL1_RST;
            auxcon_ff <= `AUXCON_RST;
            decim_ff <= `DECIM_RST;
        end else begin
            if (mode_wr) begin
                mode_ff <= sfr_req.wdata;
            end else if (finish) begin
                // Single shot and calibration fall back to idle
                mode_ff[2:0] <= MODE_IDLE;
            end
            if (sfr_req.wr && sfr_req.addr == `SFR_CTRL1) begin
                ctrl1_ff <= sfr_req.wdata;
            end
            if (sfr_req.wr && sfr_req.addr == `SFR_AUXCON) begin
                auxcon_ff <= sfr_req.wdata;
            end
            if (sfr_req.wr && sfr_req.addr == `SFR_DECIM) begin
                decim_ff <= sfr_req.wdata;
            end
        end
    end

    // ==========================================================
    // Ready flags; a hardware set wins over any clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            primary_ready_flag_ff <= 1'b0;
            aux_ready_flag_ff <= 1'b0;
        end else begin
            if (acc0) begin
                primary_ready_flag_ff <= 1'b1;
            end else if (mode_wr) begin
                primary_ready_flag_ff <= 1'b0;
            end else if (sw_we[`ST_PRIMARY_READY_FLAG]) begin
                primary_ready_flag_ff <= sw_val[`ST_PRIMARY_READY_FLAG];
            end
            if (acc1) begin
                aux_ready_flag_ff <= 1'b1;
            end else if (mode_wr) begin
                aux_ready_flag_ff <= 1'b0;
            end else if (sw_we[`ST_AUX_READY_FLAG]) begin
                aux_ready_flag_ff <= sw_val[`ST_AUX_READY_FLAG];
            end
        end
    end

    // ==========================================================
    // Calibration flag and reference detect flag
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cal_ff <= 1'b0;
            noref_ff <= 1'b0;
        end else begin
            if ((acc0 || acc1) && cal_mode) begin
                cal_ff <= 1'b1;
            end else if (mode_wr) begin
                cal_ff <= 1'b0;
            end
            // Only meaningful while a converter runs
            noref_ff <= active && ref_ff &&
                        (mode_ff[`MODE_EN0] || mode_ff[`MODE_EN1]);
        end
    end

    // ==========================================================
    // Error flags for clamped results or failed calibration
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            primary_error_flag_ff <= 1'b0;
            aux_error_flag_ff <= 1'b0;
        end else begin
            if (acc0 && clamp0) begin
                primary_error_flag_ff <= 1'b1;
            end else if (mode_wr) begin
                primary_error_flag_ff <= 1'b0;
            end else if (sw_we[`ST_PRIMARY_ERROR_FLAG]) begin
                primary_error_flag_ff <= sw_val[`ST_PRIMARY_ERROR_FLAG];
            end
            if (acc1 && clamp1) begin
                aux_error_flag_ff <= 1'b1;
            end else if (mode_wr) begin
                aux_error_flag_ff <= 1'b0;
            end else if (sw_we[`ST_AUX_ERROR_FLAG]) begin
                aux_error_flag_ff <= sw_val[`ST_AUX_ERROR_FLAG];
            end
        end
    end

    // ==========================================================
    // Result registers, written only on accepted conversions
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            res0_ff <= '0;
            res1_ff <= '0;
        end else begin
            if (acc0 && !cal_mode) begin
                res0_ff <= val0;
            end
            if (acc1 && !cal_mode) begin
                res1_ff <= val1;
            end
        end
    end

    // Calibration coefficients; a rail value leaves them untouched
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ofs0_ff <= FACTORY_OFFSET;
            gain0_ff <= FACTORY_GAIN;
        end else if (acc0 && cal_mode && !clamp0) begin
            if (mode_ff[0]) begin
                gain0_ff <= val0; // Full-scale calibration
            end else begin
                ofs0_ff <= val0;  // Zero-scale calibration
            end
        end
    end

    // ==========================================================
    // Analog setting outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chop_ff <= 1'b0;
            bufdis_ff <= 1'b0;
            range_ff <= 3'h0;
        end else begin
            chop_ff <= !mode_ff[`MODE_CHOP_OFF];
            bufdis_ff <= ctrl1_ff[`CTRL1_BUFA] &&
                         !ctrl1_ff[`CTRL1_BUFB];
            range_ff <= ctrl1_ff[2:0];
        end
    end

    // ==========================================================
    // Read answers, one cycle after the strobe
    logic [7:0] status_word; // Status as software sees it

    assign status_word = {primary_ready_flag_ff, aux_ready_flag_ff, cal_ff, noref_ff,
                          primary_error_flag_ff, aux_error_flag_ff, 2'b00};

    // Byte read mux; unmapped addresses answer zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= 8'h00;
        end else if (sfr_req.rd) begin
            case (sfr_req.addr)
                `SFR_MODE: rdata_ff <= mode_ff;
                `SFR_CTRL1: rdata_ff <= ctrl1_ff;
                `SFR_AUXCON: rdata_ff <= auxcon_ff;
                `SFR_DECIM: rdata_ff <= decim_ff;
                `SFR_STATUS: rdata_ff <= status_word;
                `SFR_RES0L: rdata_ff <= res0_ff[7:0];
                `SFR_RES0M: rdata_ff <= res0_ff[15:8];
                `SFR_RES0H: rdata_ff <= res0_ff[23:16];
                `SFR_RES1L: rdata_ff <= res1_ff[7:0];
                `SFR_RES1M: rdata_ff <= res1_ff[15:8];
                `SFR_RES1H: rdata_ff <= res1_ff[23:16];
                `SFR_OFS0L: rdata_ff <= ofs0_ff[7:0];
                `SFR_OFS0M: rdata_ff <= ofs0_ff[15:8];
                `SFR_OFS0H: rdata_ff <= ofs0_ff[23:16];
                `SFR_GAIN0L: rdata_ff <= gain0_ff[7:0];
                `SFR_GAIN0M: rdata_ff <= gain0_ff[15:8];
                `SFR_GAIN0H: rdata_ff <= gain0_ff[23:16];
                default: rdata_ff <= 8'h00;
            endcase
        end
    end

    // Single status bit test
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            brdata_ff <= 1'b0;
        end else if (bit_req.rd) begin
            if (bit_req.addr[7:3] == `SFR_STATUS >> 3) begin
                brdata_ff <= status_word[bit_req.addr[2:0]];
            end else begin
                brdata_ff <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Outputs straight from flops
    assign sfr_rdata = rdata_ff;
    assign bit_rdata = brdata_ff;
    assign primary_result = res0_ff;
    assign aux_result = res1_ff;
    assign chop_enable = chop_ff;
    assign buffer_disable = bufdis_ff;
    assign range_code = range_ff;
endmodule : adc_status_ctrl
`default_nettype wire

// ==== bench/adc_ctrl_assertions.sv ====
// Port checks for the converter status and filter control block
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_params.svh"
module adc_ctrl_assertions #(parameter int RES_W = 24) (
    input wire logic clk,
    input wire logic arst_n,
    input wire adc_ctrl_pkg::sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire adc_ctrl_pkg::bit_req_t bit_req,
    input wire logic bit_rdata,
    input wire logic ref_missing,
    input wire logic [RES_W-1:0] primary_result,
    input wire logic chop_enable,
    input wire logic buffer_disable,
    input wire logic [2:0] range_code
);
    import adc_ctrl_pkg::*;
    // ==========================================================
    // Write decodes and a shadow of the filter factor
    wire logic wm = sfr_req.wr && sfr_req.addr == `SFR_MODE;
    wire logic wc = sfr_req.wr && sfr_req.addr == `SFR_CTRL1;
    wire logic wd = sfr_req.wr && sfr_req.addr == `SFR_DECIM;
    logic [7:0] decim_ff; // Last factor written
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) decim_ff <= `DECIM_RST;
        else if (wd) decim_ff <= sfr_req.wdata;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ==========================================================
    // Assertions
    chk_chop_follow: assert property (
        wm |-> ##2 chop_enable == !$past(sfr_req.wdata[3], 2))
        else $error("chop enable wrong");
    chk_buf_decode: assert property (
        wc |-> ##2 buffer_disable == ($past(sfr_req.wdata[7:6], 2) == 2'h2))
        else $error("buffer disable wrong");
    chk_range_copy: assert property (
        wc |-> ##2 range_code == $past(sfr_req.wdata[2:0], 2))
        else $error("range code wrong");
    chk_unimpl_zero: assert property (
        sfr_req.rd && sfr_req.addr == `SFR_STATUS |=> sfr_rdata[1:0] == 2'h0)
        else $error("unused status bits not zero");
    chk_bit_low: assert property (
        bit_req.rd && bit_req.addr[7:1] == 7'h6C |=> !bit_rdata)
        else $error("unused status bit reads one");
    chk_unmapped_zero: assert property (
        sfr_req.rd && sfr_req.addr == 8'hD7 |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_factor_read: assert property (
        sfr_req.rd && sfr_req.addr == `SFR_DECIM |=> sfr_rdata == decim_ff)
        else $error("factor read back wrong");
    chk_rdata_stands: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    chk_ref_ones: assert property (
        ref_missing && $past(ref_missing, 4) && $changed(primary_result)
        |-> &primary_result)
        else $error("result not forced to ones");
    cover property (wm && sfr_req.wdata[2:0] == 3'h5);
    cover property ($changed(primary_result));
    cover property (bit_req.wr && bit_req.addr == 8'hDF);
endmodule : adc_ctrl_assertions
bind adc_status_ctrl adc_ctrl_assertions #(.RES_W(RES_W)) adc_ctrl_assertions_i (
    .clk(clk), .arst_n(arst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .bit_req(bit_req), .bit_rdata(bit_rdata), .ref_missing(ref_missing),
    .primary_result(primary_result), .chop_enable(chop_enable),
    .buffer_disable(buffer_disable), .range_code(range_code));
`default_nettype wire

// ==== bench/analog_sensors.sv ====
// Sensor front end model feeding sample levels and reference state
`timescale 1ns/10ps
`default_nettype none
module analog_sensors #(parameter int RES_W = 24) (
    input wire logic clk,
    input wire logic [RES_W-1:0] set_level,
    input wire logic set_ref_bad,
    output logic [RES_W-1:0] primary_sample,
    output logic [RES_W-1:0] aux_sample,
    output logic ref_missing
);
    // Levels move just after an edge, then hold steady for the synchroniser
    initial {primary_sample, aux_sample, ref_missing} = '0;
    always @(posedge clk) begin
        primary_sample <= set_level;
        aux_sample <= ~set_level;
        ref_missing <= set_ref_bad;
    end
endmodule : analog_sensors
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the converter status and filter control
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_params.svh"
module tb_top;
    import adc_ctrl_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    sfr_req_t sfr_req = '0;
    bit_req_t bit_req = '0;
    logic [7:0] sfr_rdata, rv;
    logic bit_rdata, chop_enable, buffer_disable, rm, ref_bad = 1'b0;
    logic [2:0] range_code;
    logic [23:0] level = 24'h000100, ps, asmp, pr, ar, hold;
    int num_errors = 0, n_tests = 0, seed = 70, el;
    time t0;
    initial forever #10 clk = ~clk;
    analog_sensors analog_sensors_i (.clk(clk), .set_level(level),
        .set_ref_bad(ref_bad), .primary_sample(ps), .aux_sample(asmp),
        .ref_missing(rm));
    adc_status_ctrl adc_status_ctrl_i (.clk(clk), .arst_n(arst_n),
        .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .bit_req(bit_req),
        .bit_rdata(bit_rdata), .primary_sample(ps), .aux_sample(asmp),
        .ref_missing(rm), .primary_result(pr), .aux_result(ar),
        .chop_enable(chop_enable), .buffer_disable(buffer_disable),
        .range_code(range_code));
    // ==========================================================
    // Verdict, compare and bus tasks
    task automatic print_verdict();
        $display("errors %0d in %0d checks", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) sfr_req <= '{a, 1'b1, 1'b0, d};
        @(posedge clk) sfr_req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk) sfr_req <= '{a, 1'b0, 1'b1, 8'h00};
        @(posedge clk) sfr_req.rd <= 1'b0;
        @(negedge clk) rv = sfr_rdata;
    endtask : rd
    task automatic bit_op(input logic [7:0] a, input logic w, input logic d);
        @(posedge clk) bit_req <= '{a, w, !w, d};
        @(posedge clk) bit_req <= '{a, 1'b0, 1'b0, d};
        @(negedge clk) rv = {7'h00, bit_rdata};
    endtask : bit_op
    // Polls status until the primary ready flag shows, bounded
    task automatic wait_rdy();
        int i;
        for (i = 0; i < 400; i++) begin
            rd(`SFR_STATUS);
            if (rv[7] === 1'b1) break;
            repeat (40) @(posedge clk);
        end
        el = int'(($time - t0) / 20);
        if (i == 400) begin
            num_errors++;
            print_verdict();
        end
    endtask : wait_rdy
    // ==========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        cmp({chop_enable, buffer_disable, range_code}, 5'h07);
        rd(`SFR_DECIM);
        cmp(rv, 8'h45);
        rd(`SFR_OFS0H);
        cmp(rv, 8'h80);
        rd(`SFR_STATUS);
        cmp(rv, 8'h00);
        rd(8'hD7);
        cmp(rv, 8'h00);
        for (int k = 0; k < 6; k++) begin
            rv = (k == 0) ? 8'h80 : 8'($random(seed));
            hold = rv;
            wr(`SFR_CTRL1, rv);
            wr(`SFR_MODE, rv & 8'h08);
            wr(`SFR_DECIM, rv);
            cmp({buffer_disable, range_code},
                {rv[7:6] == 2'h2, rv[2:0]});
            cmp(chop_enable, !rv[3]);
            rd(`SFR_DECIM);
            cmp(rv, hold);
        end
        wr(`SFR_STATUS, 8'hFF);
        rd(`SFR_STATUS);
        cmp(rv, 8'hCC);
        bit_op(8'hDF, 1'b1, 1'b0);
        bit_op(8'hDB, 1'b1, 1'b0);
        rd(`SFR_STATUS);
        cmp(rv, 8'h44);
        bit_op(8'hDE, 1'b0, 1'b0);
        cmp(rv, 8'h01);
        bit_op(8'hD9, 1'b0, 1'b0);
        wr(`SFR_STATUS, 8'h00);
        wr(`SFR_DECIM, 8'h01);
        @(posedge clk) level <= (24'($random(seed)) & 24'h7FFFFE) | 24'h100;
        t0 = $time;
        wr(`SFR_MODE, 8'h3A);
        wait_rdy();
        cmp(el >= 7 * `BASE_DIV && el <= 13800, 1'b1);
        cmp(rv, 8'hC0);
        cmp(pr, level);
        cmp(ar, ~level);
        wr(`SFR_RES0H, ~level[23:16]);
        rd(`SFR_RES0H);
        cmp(rv, level[23:16]);
        rd(`SFR_MODE);
        cmp(rv, 8'h39);
        @(posedge clk) level <= 24'h2468AC;
        wr(`SFR_MODE, 8'h2B);
        wait_rdy();
        @(posedge clk) level <= 24'h000000;
        repeat (14000) @(posedge clk);
        cmp(pr, 24'h2468AC);
        bit_op(8'hDF, 1'b1, 1'b0);
        wait_rdy();
        cmp(pr, 24'h000000);
        cmp(rv[3], 1'b1);
        @(posedge clk) {level, ref_bad} <= {24'h135790, 1'b1};
        bit_op(8'hDF, 1'b1, 1'b0);
        repeat (2) @(posedge clk);
        rd(`SFR_STATUS);
        cmp(rv[4], 1'b1);
        wait_rdy();
        cmp(pr, 24'hFFFFFF);
        @(posedge clk) ref_bad <= 1'b0;
        t0 = $time;
        wr(`SFR_MODE, 8'h2D);
        wait_rdy();
        cmp(el <= 13800, 1'b1);
        cmp(rv, 8'hA0);
        rd(`SFR_GAIN0H);
        cmp(rv, 8'h13);
        wr(`SFR_MODE, 8'h21);
        rd(`SFR_STATUS);
        cmp(rv, 8'h00);
        wr(`SFR_AUXCON, 8'h0F);
        wr(`SFR_MODE, 8'h1D);
        repeat (14000) @(posedge clk);
        rd(`SFR_STATUS);
        cmp(rv, 8'h00);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
